// file: verilog/mrc_defs.svh
// constants for the mode register two and output control decode
`ifndef MRC_DEFS_SVH
`define MRC_DEFS_SVH
`define MRC_MR_W 22
`define MRC_SEL_HI 20
`define MRC_SEL_LO 18
`define MRC_SEL_MR0 3'h0
`define MRC_SEL_MR1 3'h1
`define MRC_SEL_MR2 3'h2
`define MRC_SEL_DNU 3'h7
`define MRC_MR2_RSV_MASK 22'h222107
`define MRC_MR2_CRC_BIT 12
`define MRC_MR2_WTERM_HI 11
`define MRC_MR2_WTERM_LO 9
`define MRC_MR2_SRR_HI 7
`define MRC_MR2_SRR_LO 6
`define MRC_MR2_CWL_HI 5
`define MRC_MR2_CWL_LO 3
`define MRC_MR1_QOFF_BIT 12
`define MRC_MR1_EXTRA_TERM_STROBE_BIT 11
`define MRC_MR1_AL_HI 4
`define MRC_MR1_AL_LO 3
`define MRC_MR0_CL_HI 6
`define MRC_MR0_CL_LO 2
`define MRC_CL_BASE 6'h09
`define MRC_WTERM_MAX 3'h4
`define MRC_CWL_MIN_2PRE 3'h4
`define MRC_LAT_W 6
// cas write delay in clocks, one per field code
`define MRC_CWL_CYC0 6'h09
`define MRC_CWL_CYC1 6'h0A
`define MRC_CWL_CYC2 6'h0B
`define MRC_CWL_CYC3 6'h0C
`define MRC_CWL_CYC4 6'h0E
`define MRC_CWL_CYC5 6'h10
`define MRC_CWL_CYC6 6'h12
`define MRC_CWL_CYC7 6'h14
// codes not allowed in gear-down
`define MRC_CWL_GD_NO_A 3'h0
`define MRC_CWL_GD_NO_B 3'h2
// due flag is raised two counts early to cover the counter and the output flop
`define MRC_DUE_LEAD 6'h02
`endif

// file: verilog/mrc_pkg.sv
// types shared by both ends of the mode register link
`default_nettype none
package mrc_pkg;
    typedef enum logic [2:0] {
        MRC_WT_OFF = 3'h0,
        MRC_WT_120 = 3'h1,
        MRC_WT_240 = 3'h2,
        MRC_WT_HIZ = 3'h3,
        MRC_WT_80 = 3'h4
    } mrc_wterm_t;
    typedef enum logic [1:0] {
        MRC_SRR_NORMAL = 2'h0,
        MRC_SRR_REDUCED = 2'h1,
        MRC_SRR_EXTENDED = 2'h2,
        MRC_SRR_AUTO = 2'h3
    } mrc_srr_t;
endpackage
`default_nettype wire

// file: verilog/mrc_cmd_if.sv
// command pins between controller and device
`default_nettype none
interface mrc_cmd_if;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [1:0] bg;
    logic [1:0] ba;
    logic [17:0] addr;
    modport ctrl (output ras_n, output cas_n, output we_n, output bg, output ba, output addr);
    modport dev (input ras_n, input cas_n, input we_n, input bg, input ba, input addr);
endinterface
`default_nettype wire

// file: verilog/mrc_cwl_decode.sv
// cas write delay code to clock count
`include "mrc_defs.svh"
`default_nettype none
module mrc_cwl_decode
(
    input wire logic [2:0] code,
    input wire logic two_cycle_preamble,
    output logic [`MRC_LAT_W-1:0] cycles,
    output logic legal
);
    // whole clocks only, no half-clock settings exist [RULE18]
    always_comb
    begin
        case (code) // [RULE14]
            3'h0: cycles = `MRC_CWL_CYC0;
            3'h1: cycles = `MRC_CWL_CYC1;
            3'h2: cycles = `MRC_CWL_CYC2;
            3'h3: cycles = `MRC_CWL_CYC3;
            3'h4: cycles = `MRC_CWL_CYC4;
            3'h5: cycles = `MRC_CWL_CYC5;
            3'h6: cycles = `MRC_CWL_CYC6;
            default: cycles = `MRC_CWL_CYC7;
        endcase
        legal = !two_cycle_preamble || (code >= `MRC_CWL_MIN_2PRE); // [RULE15]
    end
endmodule // mrc_cwl_decode
`default_nettype wire

// file: verilog/mrc_device.sv
// device end: mode register decode for write settings and output control
// Summary of operation
// RULE1: output disable bit disconnects all outputs; code gates only extra_term_strobe with it
// RULE2: controller keeps output disable at zero
// RULE3: termination strobe only allowed in x8
// RULE4: without strobe pins, termination applies to dqs
// RULE5: strobe enabled removes mask and inversion
// RULE6: mask and write inversion never both
// RULE7: mode set uses ras cas we low
// RULE8: bank group, bank, address map to bits
// RULE9: bits 20:18 select register, 111 unused
// RULE10: reserved bits programmed to zero
// RULE11: bit 12 enables write crc
// RULE12: bits 11:9 set write termination
// RULE13: bits 7:6 pick self refresh range
// RULE14: one-cycle preamble write delay codes
// RULE15: two-cycle preamble rejects codes below 100
// RULE16: no 9 or 11 in gear-down
// RULE17: delay counts command to first data
// RULE18: only whole clock latencies
// RULE19: total latency is added plus parity plus cas
// RULE20: added latency zero, cl-1, cl-2, reserved
// RULE21: fields hold until next set or reset
`include "mrc_defs.svh"
`default_nettype none
module mrc_device
    import mrc_pkg::*;
#(
    parameter bit BYTE_WIDE = 1'b1
)
(
    input wire logic core_clk,
    input wire logic reset,
    mrc_cmd_if.dev cmd,
    input wire logic two_cycle_preamble,
    input wire logic gear_down,
    input wire logic [`MRC_LAT_W-1:0] parity_latency,
    input wire logic write_mask_req,
    input wire logic write_inv_req,
    input wire logic read_inv_req,
    input wire logic write_cmd,
    output logic outputs_off,
    output logic write_crc_en,
    output mrc_wterm_t write_termination,
    output mrc_srr_t lowpower_selfrefresh_range,
    output logic extra_term_strobe,
    output logic dqs_term_en,
    output logic write_byte_mask,
    output logic write_bus_inversion,
    output logic read_bus_inversion,
    output logic [`MRC_LAT_W-1:0] cas_write_delay,
    output logic [`MRC_LAT_W-1:0] added_latency,
    output logic [`MRC_LAT_W-1:0] total_write_latency,
    output logic write_data_due,
    output logic setting_error
);
    ////////////////////////////////////////////////////////////////////////////
    logic mrs_hit;
    logic [`MRC_MR_W-1:0] mr_word;
    logic [2:0] sel;
    logic [`MRC_MR_W-1:0] mr0_reg;
    logic [`MRC_MR_W-1:0] mr1_reg;
    logic [`MRC_MR_W-1:0] write_mode_config_reg;
    logic [`MRC_LAT_W-1:0] cwl_cycles;
    logic cwl_legal;
    logic [`MRC_LAT_W-1:0] cl_cycles;
    logic [`MRC_LAT_W-1:0] al_cycles;
    logic [`MRC_LAT_W-1:0] wl_cycles;
    logic strobe_on;
    logic [`MRC_LAT_W-1:0] due_cnt_reg;
    logic [2:0] cwl_code;

    assign mrs_hit = !cmd.ras_n && !cmd.cas_n && !cmd.we_n; // [RULE7]
    assign mr_word = {cmd.bg, cmd.ba, cmd.addr}; // [RULE8]
    assign sel = mr_word[`MRC_SEL_HI:`MRC_SEL_LO]; // [RULE9]

    ////////////////////////////////////////////////////////////////////////////
    // held until the next set to the same register or reset [RULE21]
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            mr0_reg <= '0;
            mr1_reg <= '0;
            write_mode_config_reg <= '0;
        end
        else if (mrs_hit && sel != `MRC_SEL_DNU) // [RULE9]
        begin
            if (sel == `MRC_SEL_MR0)
                mr0_reg <= mr_word;
            else if (sel == `MRC_SEL_MR1)
                mr1_reg <= mr_word;
            else if (sel == `MRC_SEL_MR2)
                write_mode_config_reg <= mr_word;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    assign cwl_code = write_mode_config_reg[`MRC_MR2_CWL_HI:`MRC_MR2_CWL_LO];
    mrc_cwl_decode u_cwl
    (
        .code(cwl_code),
        .two_cycle_preamble(two_cycle_preamble),
        .cycles(cwl_cycles),
        .legal(cwl_legal)
    );

    // read cas delay kept simple: base plus the mr0 field, enough for the subtraction
    assign cl_cycles = `MRC_CL_BASE + {1'b0, mr0_reg[`MRC_MR0_CL_HI:`MRC_MR0_CL_LO]};

    always_comb
    begin
        case (mr1_reg[`MRC_MR1_AL_HI:`MRC_MR1_AL_LO]) // [RULE20]
            2'h1: al_cycles = cl_cycles - 6'h01;
            2'h2: al_cycles = cl_cycles - 6'h02;
            default: al_cycles = '0;
        endcase
    end

    assign wl_cycles = al_cycles + parity_latency + cwl_cycles; // [RULE19]
    // a narrow device has no strobe pins, so the bit does not set strobe_on there; it drives dqs_term_en and setting_error [RULE3]
    assign strobe_on = BYTE_WIDE && mr1_reg[`MRC_MR1_EXTRA_TERM_STROBE_BIT];

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            outputs_off <= 1'b0;
            write_crc_en <= 1'b0;
            write_termination <= MRC_WT_OFF;
            lowpower_selfrefresh_range <= MRC_SRR_NORMAL;
            cas_write_delay <= '0;
            added_latency <= '0;
            total_write_latency <= '0;
        end
        else
        begin
            outputs_off <= mr1_reg[`MRC_MR1_QOFF_BIT]; // [RULE1]
            write_crc_en <= write_mode_config_reg[`MRC_MR2_CRC_BIT]; // [RULE11]
            // reserved codes fall back to off rather than an unknown value
            if (write_mode_config_reg[`MRC_MR2_WTERM_HI:`MRC_MR2_WTERM_LO] <= `MRC_WTERM_MAX)
                write_termination <= mrc_wterm_t'(
                    write_mode_config_reg[`MRC_MR2_WTERM_HI:`MRC_MR2_WTERM_LO]); // [RULE12]
            else
                write_termination <= MRC_WT_OFF;
            lowpower_selfrefresh_range <= mrc_srr_t'(
                write_mode_config_reg[`MRC_MR2_SRR_HI:`MRC_MR2_SRR_LO]); // [RULE13]
            cas_write_delay <= cwl_cycles; // [RULE14]
            added_latency <= al_cycles;
            total_write_latency <= wl_cycles; // [RULE19]
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            extra_term_strobe <= 1'b0;
            dqs_term_en <= 1'b0;
            write_byte_mask <= 1'b0;
            write_bus_inversion <= 1'b0;
            read_bus_inversion <= 1'b0;
        end
        else
        begin
            extra_term_strobe <= strobe_on && !mr1_reg[`MRC_MR1_QOFF_BIT]; // [RULE1]
            dqs_term_en <= !BYTE_WIDE && mr1_reg[`MRC_MR1_EXTRA_TERM_STROBE_BIT]; // [RULE4]
            // mask wins over write inversion if both are asked for [RULE6]
            write_byte_mask <= !strobe_on && write_mask_req; // [RULE5]
            write_bus_inversion <= !strobe_on && write_inv_req && !write_mask_req; // [RULE6]
            read_bus_inversion <= !strobe_on && read_inv_req; // [RULE5]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // counts from the write command to the first data beat; a new write restarts it
    always_ff @(posedge core_clk)
    begin
        if (reset)
            due_cnt_reg <= '0;
        else if (write_cmd)
            due_cnt_reg <= wl_cycles; // [RULE17]
        else if (due_cnt_reg != '0)
            due_cnt_reg <= due_cnt_reg - 6'h01;
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
            write_data_due <= 1'b0;
        else
            write_data_due <= (due_cnt_reg == `MRC_DUE_LEAD); // [RULE19]
    end

    // flags settings the controller should never have sent
    always_ff @(posedge core_clk)
    begin
        if (reset)
            setting_error <= 1'b0;
        else
            setting_error <= !cwl_legal // [RULE15]
                || (gear_down && (cwl_code == `MRC_CWL_GD_NO_A
                    || cwl_code == `MRC_CWL_GD_NO_B)) // [RULE16]
                || ((write_mode_config_reg & `MRC_MR2_RSV_MASK) != '0) // [RULE10]
                || (!BYTE_WIDE && mr1_reg[`MRC_MR1_EXTRA_TERM_STROBE_BIT]); // [RULE3]
    end
endmodule // mrc_device
`default_nettype wire

// file: verilog/mrc_ctrl.sv
// controller end: issues mode register set commands
`include "mrc_defs.svh"
`default_nettype none
module mrc_ctrl
    import mrc_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset,
    mrc_cmd_if.ctrl cmd,
    input wire logic set_req,
    input wire logic [2:0] set_sel,
    input wire logic [17:0] set_value,
    input wire logic byte_wide,
    input wire logic gear_down,
    output logic set_done,
    output logic set_refused
);
    logic [`MRC_MR_W-1:0] word;
    logic ok;
    logic [2:0] cwl_code;

    ////////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        word = {1'b0, set_sel, set_value};
        cwl_code = set_value[`MRC_MR2_CWL_HI:`MRC_MR2_CWL_LO];
        ok = set_sel != `MRC_SEL_DNU; // [RULE9]
        if (set_sel == `MRC_SEL_MR2)
        begin
            word = word & ~`MRC_MR2_RSV_MASK; // [RULE10]
            if (gear_down && (cwl_code == `MRC_CWL_GD_NO_A || cwl_code == `MRC_CWL_GD_NO_B))
                ok = 1'b0; // [RULE16]
        end
        if (set_sel == `MRC_SEL_MR1)
        begin
            word[`MRC_MR1_QOFF_BIT] = 1'b0; // [RULE2]
            if (!byte_wide)
                word[`MRC_MR1_EXTRA_TERM_STROBE_BIT] = 1'b0; // [RULE3]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            cmd.ras_n <= 1'b1;
            cmd.cas_n <= 1'b1;
            cmd.we_n <= 1'b1;
            cmd.bg <= '0;
            cmd.ba <= '0;
            cmd.addr <= '0;
            set_done <= 1'b0;
            set_refused <= 1'b0;
        end
        else
        begin
            set_done <= set_req && ok;
            set_refused <= set_req && !ok;
            cmd.ras_n <= !(set_req && ok); // [RULE7]
            cmd.cas_n <= !(set_req && ok);
            cmd.we_n <= !(set_req && ok);
            if (set_req && ok)
            begin
                cmd.bg <= word[21:20]; // [RULE8]
                cmd.ba <= word[19:18];
                cmd.addr <= word[17:0];
            end
        end
    end
endmodule // mrc_ctrl
`default_nettype wire

// file: verif/mrc_checker.sv
// assertion checker on the mode register command pins
`default_nettype none
module mrc_checker
(
    input wire logic core_clk,
    input wire logic reset,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [1:0] bg,
    input wire logic [1:0] ba,
    input wire logic [17:0] addr
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (reset);
    wire logic [2:0] sel = {bg[0], ba};
    ////////////////////////////////////////////////////////////////
    sequence s_mrs;
        !ras_n && !cas_n && !we_n;
    endsequence
    sequence s_mr2;
        s_mrs ##0 sel == 3'h2;
    endsequence
    property p_trio;
        (!ras_n || !cas_n || !we_n) |-> s_mrs;
    endproperty
    property p_sel_ok;
        s_mrs |-> sel != 3'h7;
    endproperty
    property p_bit21;
        s_mrs |-> !bg[1];
    endproperty
    property p_mr2_rsv;
        s_mr2 |-> (addr & 18'h22107) == 18'h00000;
    endproperty
    property p_qoff;
        s_mrs ##0 sel == 3'h1 |-> !addr[12];
    endproperty
    // a mid-run reset clears the pins, so skip the edge right after it
    property p_hold;
        ras_n && !$past(reset) |-> $stable({bg, ba, addr});
    endproperty
    // must also hold across reset, so no disable here
    property p_reset_idle;
        disable iff (1'b0) reset |=> ras_n && cas_n && we_n;
    endproperty
    property p_no_early;
        s_mrs |-> !$past(reset);
    endproperty
    a_trio: assert property (p_trio) else $error("command pins split");
    a_sel_ok: assert property (p_sel_ok) else $error("unused select sent");
    a_bit21: assert property (p_bit21) else $error("bit 21 set");
    a_mr2_rsv: assert property (p_mr2_rsv) else $error("reserved bit set");
    a_qoff: assert property (p_qoff) else $error("output disable sent");
    a_hold: assert property (p_hold) else $error("pins moved when idle");
    a_reset_idle: assert property (p_reset_idle) else $error("pins not idle");
    a_no_early: assert property (p_no_early) else $error("command in reset");
endmodule // mrc_checker
`default_nettype wire

// file: verif/sdram_mode_reg_two_and_output_ctl_tb_top.sv
// bench joining controller and device ends
`default_nettype none
module sdram_mode_reg_two_and_output_ctl_tb_top
    import mrc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic core_clk = 1'b0, reset = 1'b1, set_req = 1'b0, byte_wide = 1'b1;
    logic gear_down = 1'b0, two_cycle_preamble = 1'b0, write_cmd = 1'b0;
    logic write_mask_req = 1'b0, write_inv_req = 1'b0, read_inv_req = 1'b0;
    logic [2:0] set_sel = 3'h0;
    logic [17:0] set_value = 18'h00000;
    logic [5:0] parity_latency = 6'h02;
    logic set_done, set_refused, outputs_off, write_crc_en, extra_term_strobe;
    logic dqs_term_en, write_byte_mask, write_bus_inversion, read_bus_inversion;
    logic write_data_due, setting_error;
    logic [5:0] cas_write_delay, added_latency, total_write_latency;
    mrc_wterm_t write_termination;
    mrc_srr_t lowpower_selfrefresh_range;
    int num_errors = 0, compares = 0, cyc = 0;
    always #2.5 core_clk = ~core_clk;
    ////////////////////////////////////////////////////////////////
    mrc_cmd_if cmd_bus ();
    mrc_ctrl i_mrc_ctrl (.core_clk, .reset, .cmd(cmd_bus.ctrl), .set_req, .set_sel,
        .set_value, .byte_wide, .gear_down, .set_done, .set_refused);
    mrc_device #(.BYTE_WIDE(1'b1)) i_mrc_device (.core_clk, .reset, .cmd(cmd_bus.dev),
        .two_cycle_preamble, .gear_down, .parity_latency, .write_mask_req,
        .write_inv_req, .read_inv_req, .write_cmd, .outputs_off, .write_crc_en,
        .write_termination, .lowpower_selfrefresh_range, .extra_term_strobe,
        .dqs_term_en, .write_byte_mask, .write_bus_inversion, .read_bus_inversion,
        .cas_write_delay, .added_latency, .total_write_latency, .write_data_due,
        .setting_error);
    mrc_checker i_mrc_checker (.core_clk, .reset, .ras_n(cmd_bus.ras_n),
        .cas_n(cmd_bus.cas_n), .we_n(cmd_bus.we_n), .bg(cmd_bus.bg), .ba(cmd_bus.ba),
        .addr(cmd_bus.addr));
    ////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        $display("compares=%0d num_errors=%0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    always @(posedge core_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 3000)
        begin
            num_errors++;
            tally_and_finish();
        end
    end
    task automatic ck(input logic ok, input string m);
        compares++;
        if (ok !== 1'b1)
        begin
            num_errors++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask
    // pin check expects the controller to clear reserved and output-off bits
    task automatic mrs(input logic [2:0] s, input logic [17:0] v, input logic rf);
        logic [17:0] m;
        m = (s == 3'h2) ? 18'h1DEF8 : (s == 3'h1) ? (byte_wide ? 18'h3EFFF : 18'h3E7FF)
            : 18'h3FFFF;
        @(negedge core_clk);
        set_req = 1'b1;
        set_sel = s;
        set_value = v;
        @(negedge core_clk);
        set_req = 1'b0;
        ck(set_refused === rf && set_done === !rf, "answer");
        ck(rf || {cmd_bus.bg, cmd_bus.ba, cmd_bus.addr} === {1'b0, s, v & m}, "pins");
        repeat (2) @(negedge core_clk);
    endtask
    task automatic rst_chk();
        @(negedge core_clk);
        reset = 1'b1;
        repeat (4) @(negedge core_clk);
        reset = 1'b0;
        @(negedge core_clk);
        ck(cas_write_delay === 6'h09 && total_write_latency === 6'h0B, "rst wl");
        ck({write_crc_en, outputs_off, added_latency} === 8'h00, "rst");
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic t_cwl();
        int d[8] = '{9, 10, 11, 12, 14, 16, 18, 20};
        for (int p = 0; p < 2; p++)
        begin
            two_cycle_preamble = p[0];
            for (int c = 4 * p; c < 8; c++)
            begin
                mrs(3'h2, 18'(c << 3), 1'b0);
                ck(cas_write_delay === 6'(d[c]) && setting_error === 1'b0, "cwl");
                ck(total_write_latency === 6'(d[c] + 2), "wl");
            end
        end
        mrs(3'h2, 18'h00008, 1'b0);
        ck(setting_error === 1'b1, "short code");
        two_cycle_preamble = 1'b0;
    endtask
    task automatic t_fields();
        for (int i = 0; i < 6; i++)
        begin
            // reserved bits are sent on purpose: the controller must strip them
            mrs(3'h2, 18'((i << 9) | ((i & 3) << 6) | ((i & 1) << 12) | 32'h22127), 1'b0);
            ck(write_crc_en === 1'(i & 1), "crc");
            ck(setting_error === 1'b0, "rsv");
            ck(write_termination === 3'(i < 5 ? i : 0), "term");
            ck(lowpower_selfrefresh_range === 2'(i & 3), "range");
        end
    endtask
    task automatic t_refuse();
        gear_down = 1'b1;
        mrs(3'h2, 18'h00000, 1'b1);
        mrs(3'h2, 18'h00010, 1'b1);
        mrs(3'h7, 18'h00000, 1'b1);
        ck(cas_write_delay === 6'h0E, "kept");
        mrs(3'h2, 18'h00008, 1'b0);
        ck(cas_write_delay === 6'h0A, "gear ten");
        gear_down = 1'b0;
    endtask
    // shared pin: strobe on, then mask over write inversion, then inversion alone
    task automatic t_mr1();
        write_mask_req = 1'b1;
        write_inv_req = 1'b1;
        read_inv_req = 1'b1;
        mrs(3'h1, 18'h01808, 1'b0);
        ck(outputs_off === 1'b0, "qoff");
        ck({extra_term_strobe, dqs_term_en, write_byte_mask, write_bus_inversion,
            read_bus_inversion} === 5'h10, "strobe");
        ck(added_latency === 6'h08 && total_write_latency === 6'h14, "al");
        mrs(3'h1, 18'h00010, 1'b0);
        ck({write_byte_mask, write_bus_inversion, read_bus_inversion} === 3'h5, "mask");
        ck(added_latency === 6'h07 && cas_write_delay === 6'h0A, "al2");
        write_mask_req = 1'b0;
        read_inv_req = 1'b0;
        repeat (2) @(negedge core_clk);
        ck({write_byte_mask, write_bus_inversion, read_bus_inversion} === 3'h2, "inv");
    endtask
    task automatic t_write();
        int n;
        @(negedge core_clk);
        write_cmd = 1'b1;
        @(negedge core_clk);
        write_cmd = 1'b0;
        n = 1;
        while (write_data_due !== 1'b1 && n < 64)
        begin
            @(negedge core_clk);
            n++;
        end
        ck(n == 19, "due");
    endtask
    // narrow controller must strip the strobe bit before it reaches the device
    task automatic t_narrow();
        byte_wide = 1'b0;
        mrs(3'h1, 18'h00810, 1'b0);
        ck(extra_term_strobe === 1'b0 && setting_error === 1'b0, "narrow");
        byte_wide = 1'b1;
    endtask
    initial
    begin
        rst_chk();
        t_cwl();
        t_fields();
        t_refuse();
        t_mr1();
        t_write();
        t_narrow();
        rst_chk();
        tally_and_finish();
    end
endmodule // sdram_mode_reg_two_and_output_ctl_tb_top
`default_nettype wire
